// ===== rtl/snp_pkg.sv
// Behaviour
// - Length zero: release on delimiter or full
// - Length 1..1024: release at that count
// - First delimiter byte, or the second if enabled, releases the buffer
// - Full buffer always releases, delimiters or not
// - Delimiter action needs first; both bytes
// - No action: release on delimiter itself
// - Plus one/two: release after extra bytes
// - Strip: delimiter bytes dropped, except a first one already released
// - Gap setting zero disables gap release
// - Release after gap longer than setting
// - Link-loss low: drop RTS and DTR
// - Link-loss high: link leaves lines alone
// - Probe periodically; close on missing answer
// - Alive time zero: no probes, no close
// - Wait for all hosts, or skip jammed
// - Driver commands ignored or latest wins
// - At most two hosts; one destination needed
package snp_pkg;

    // ******************************
    // Sizes and timing
    // ******************************
    localparam int BUF_BYTES = 1024;
    localparam int CNT_W = 11;
    localparam int IDX_W = 10;
    localparam int TOT_W = 12;
    localparam int GAP_W = 16;
    localparam int ALIVE_W = 7;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_MIN = 60000;
    localparam int ALIVE_DEF_MIN = 7;

    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [TOT_W-1:0] TOT_FULL = 12'h400;
    localparam logic [1:0] TAIL_ONE = 2'h1;
    localparam logic [1:0] TAIL_TWO = 2'h2;
    localparam int CMD_RTS_BIT = 0;
    localparam int CMD_DTR_BIT = 1;

    // ******************************
    // Types
    // ******************************
    typedef logic [7:0] snp_byte_t;

    typedef enum logic [1:0] {
        DA_NONE,
        DA_PLUS1,
        DA_PLUS2,
        DA_STRIP
    } snp_dact_e;

    typedef enum logic [1:0] {
        DS_IDLE,
        DS_GOT1,
        DS_TAIL
    } snp_dstate_e;

    typedef struct packed {
        logic [CNT_W-1:0] pack_len;
        logic d1_en;
        snp_byte_t d1;
        logic d2_en;
        snp_byte_t d2;
        snp_dact_e dact;
        logic [GAP_W-1:0] gap_ms;
        logic [ALIVE_W-1:0] alive_min;
        logic link_low;
        logic skip_jam;
        logic drv_ctl_en;
        logic max_two;
        logic [1:0] dest_en;
    } snp_cfg_s;

    typedef struct packed {
        logic valid;
        snp_byte_t cmd;
    } snp_hcmd_s;

endpackage

// ===== rtl/snp_gap_timer.sv
`timescale 1ns/1ps
module snp_gap_timer #(
    parameter int CYC_PER_MS_P = snp_pkg::CYC_PER_MS
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Async reset
    input wire logic byte_seen_in, // Serial byte taken
    input wire logic [snp_pkg::GAP_W-1:0] gap_ms_in, // Gap setting
    output logic ms_tick_out, // One per ms
    output logic expired_out // Gap exceeded
);
    import snp_pkg::*;

    localparam int PW = $clog2(CYC_PER_MS_P);
    localparam logic [PW-1:0] PRESC_END = PW'(CYC_PER_MS_P - 1);

    logic [PW-1:0] presc_reg;
    logic [GAP_W:0] gap_cnt_reg;
    wire presc_wrap = presc_reg == PRESC_END;
    wire cnt_sat = &gap_cnt_reg;
    // Saturating count; a stuck line cannot wrap and refire
    wire [GAP_W:0] gap_cnt_next = byte_seen_in ? '0 :
        (ms_tick_out && !cnt_sat) ? gap_cnt_reg + 1'b1 : gap_cnt_reg;
    wire expired_next = (gap_ms_in != '0) && !byte_seen_in &&
        (gap_cnt_reg > {1'b0, gap_ms_in});

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_reg <= '0;
            ms_tick_out <= 1'b0;
        end else begin
            presc_reg <= presc_wrap ? '0 : presc_reg + 1'b1;
            ms_tick_out <= presc_wrap;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_cnt_reg <= '0;
            expired_out <= 1'b0;
        end else begin
            gap_cnt_reg <= gap_cnt_next;
            expired_out <= expired_next;
        end
    end

endmodule

// ===== rtl/snp_keepalive.sv
`timescale 1ns/1ps
module snp_keepalive #(
    parameter int MS_PER_MIN_P = snp_pkg::MS_PER_MIN
) (
    input wire logic clk_in, // System clock
    input wire logic rst_n_in, // Async reset
    input wire logic ms_tick_in, // One per ms
    input wire logic [snp_pkg::ALIVE_W-1:0] alive_min_in, // Minutes
    input wire logic link_up_in, // Link up
    input wire logic ack_in, // Probe answered
    output logic probe_out, // Send probe
    output logic close_out // Close link
);
    import snp_pkg::*;

    localparam int MW = $clog2(MS_PER_MIN_P);
    localparam logic [MW-1:0] MS_END = MW'(MS_PER_MIN_P - 1);

    logic [MW-1:0] ms_cnt_reg;
    logic [ALIVE_W-1:0] min_cnt_reg;
    logic waiting_reg;

    wire active = (alive_min_in != '0) && link_up_in;
    wire min_tick = active && ms_tick_in && (ms_cnt_reg == MS_END);
    wire [ALIVE_W-1:0] min_inc = min_cnt_reg + 1'b1;
    wire period_end = min_tick && (min_inc >= alive_min_in);
    // Unanswered probe at period end closes
    wire close_next = period_end && waiting_reg && !ack_in;
    wire probe_next = period_end && !close_next;
    wire waiting_next = !active ? 1'b0 : probe_next ? 1'b1 :
        (ack_in || close_next) ? 1'b0 : waiting_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ms_cnt_reg <= '0;
            min_cnt_reg <= '0;
        end else if (!active) begin
            ms_cnt_reg <= '0;
            min_cnt_reg <= '0;
        end else if (ms_tick_in) begin
            ms_cnt_reg <= (ms_cnt_reg == MS_END) ? '0 : ms_cnt_reg + 1'b1;
            min_cnt_reg <= period_end ? '0 :
                min_tick ? min_inc : min_cnt_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            waiting_reg <= 1'b0;
            probe_out <= 1'b0;
            close_out <= 1'b0;
        end else begin
            waiting_reg <= waiting_next;
            probe_out <= probe_next;
            close_out <= close_next;
        end
    end

endmodule

// ===== rtl/snp_packer.sv
`timescale 1ns/1ps
module snp_packer #(
    parameter int CYC_PER_MS_P = snp_pkg::CYC_PER_MS,
    parameter int MS_PER_MIN_P = snp_pkg::MS_PER_MIN
) (
    input wire logic CLK_SYS_IN, // System clock
    input wire logic RST_N_IN, // Async reset, low
    input wire snp_pkg::snp_cfg_s CFG_IN, // Port settings
    input wire logic RX_VALID_IN, // Serial byte valid
    input wire snp_pkg::snp_byte_t RX_DATA_IN, // Serial byte
    output logic RX_READY_OUT, // Room for a byte
    output logic TX_VALID_OUT, // Network byte valid
    output snp_pkg::snp_byte_t TX_DATA_OUT, // Network byte
    output logic TX_LAST_OUT, // Last of packet
    output logic [1:0] TX_DEST_OUT, // Hosts addressed
    input wire logic [1:0] TX_READY_IN, // Host takes byte
    input wire logic [1:0] HOST_CONN_IN, // Host connected
    input wire logic [1:0] HOST_JAM_IN, // Host not responding
    input wire snp_pkg::snp_hcmd_s [1:0] HOST_CMD_IN, // Driver commands
    input wire logic LINK_UP_IN, // Network link up
    input wire logic PROBE_ACK_IN, // Probe answered
    output logic PROBE_OUT, // Send probe
    output logic CLOSE_OUT, // Close connection
    output logic RTS_OUT, // Modem RTS level
    output logic DTR_OUT, // Modem DTR level
    output logic CMD_VALID_OUT, // Command accepted
    output snp_pkg::snp_byte_t CMD_OUT, // Accepted command
    output logic CFG_ERR_OUT // No destination set
);
    import snp_pkg::*;

    // ******************************
    // State
    // ******************************
    snp_byte_t buf_mem [BUF_BYTES];
    logic [IDX_W-1:0] wr_idx_reg;
    logic [IDX_W-1:0] rd_idx_reg;
    logic [CNT_W-1:0] acc_reg;
    logic [CNT_W-1:0] send_reg;
    logic [CNT_W-1:0] pend_reg;
    logic pend_vld_reg;
    logic [1:0] tail_reg;
    snp_dstate_e dstate_reg;
    logic [1:0] need_reg;
    logic rts_req_reg;
    logic dtr_req_reg;
    logic ms_tick;
    logic gap_expired;
    wire byte_in = RX_VALID_IN && RX_READY_OUT;

    // ******************************
    // Timers
    // ******************************
    snp_gap_timer #(
        .CYC_PER_MS_P(CYC_PER_MS_P)
    ) u_gap (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .byte_seen_in(byte_in),
        .gap_ms_in(CFG_IN.gap_ms),
        .ms_tick_out(ms_tick),
        .expired_out(gap_expired)
    );

    snp_keepalive #(
        .MS_PER_MIN_P(MS_PER_MIN_P)
    ) u_alive (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .ms_tick_in(ms_tick),
        .alive_min_in(CFG_IN.alive_min),
        .link_up_in(LINK_UP_IN),
        .ack_in(PROBE_ACK_IN),
        .probe_out(PROBE_OUT),
        .close_out(CLOSE_OUT)
    );

    // ******************************
    // Delimiter detection
    // ******************************
    // A length limit in force disables delimiters
    wire delim_on = (CFG_IN.pack_len == CNT_ZERO) && CFG_IN.d1_en;
    // Second delimiter alone never arms matching
    wire two = delim_on && CFG_IN.d2_en;
    wire hit1 = RX_DATA_IN == CFG_IN.d1;
    wire hit2 = RX_DATA_IN == CFG_IN.d2;
    wire strip = CFG_IN.dact == DA_STRIP;
    wire plus = (CFG_IN.dact == DA_PLUS1) || (CFG_IN.dact == DA_PLUS2);
    wire [1:0] tail_init = (CFG_IN.dact == DA_PLUS2) ? TAIL_TWO : TAIL_ONE;
    wire complete = byte_in && delim_on && (two ?
        (dstate_reg == DS_GOT1 && hit2) :
        (dstate_reg != DS_TAIL && hit1));
    wire tail_done = byte_in && (dstate_reg == DS_TAIL) &&
        (tail_reg == TAIL_ONE);
    // First of two delimiters is already stored: take it back
    wire drop = complete && strip;
    wire rewind = drop && two && (acc_reg != CNT_ZERO);
    wire store = byte_in && !drop;
    wire delim_rel = (complete && !plus) || tail_done;

    // ******************************
    // Release decision
    // ******************************
    wire [CNT_W-1:0] acc_after = acc_reg + CNT_W'(store) - CNT_W'(rewind);
    wire [TOT_W-1:0] total_after = TOT_W'(acc_after) + TOT_W'(send_reg) +
        TOT_W'(pend_reg);
    wire len_hit = (CFG_IN.pack_len != CNT_ZERO) &&
        (acc_after == CFG_IN.pack_len);
    wire full = total_after == TOT_FULL;
    wire gap_rel = gap_expired && !byte_in;
    wire want_rel = (acc_after != CNT_ZERO) &&
        (len_hit || delim_rel || full || gap_rel);
    // Only one packet may wait behind the one in flight
    wire rel = want_rel && !pend_vld_reg;

    // ******************************
    // Network side
    // ******************************
    wire [1:0] conn_eff = HOST_CONN_IN & {CFG_IN.max_two, 1'b1};
    logic [1:0] need_next;
    logic [1:0] cmd_hit;
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_host
            assign need_next[h] = conn_eff[h] &&
                !(CFG_IN.skip_jam && HOST_JAM_IN[h]);
            assign cmd_hit[h] = HOST_CMD_IN[h].valid && conn_eff[h] &&
                CFG_IN.drv_ctl_en;
        end
    endgenerate
    // All addressed hosts must take a byte; all skipped drops it
    wire all_skipped = (need_reg == 2'h0) && (conn_eff != 2'h0);
    wire take = TX_VALID_OUT && (&(TX_READY_IN | ~need_reg)) &&
        ((need_reg != 2'h0) || all_skipped);
    wire load = (send_reg != CNT_ZERO) && (!TX_VALID_OUT || take);
    wire [CNT_W-1:0] send_dec = send_reg - CNT_W'(load);

    logic [CNT_W-1:0] acc_next;
    logic [CNT_W-1:0] send_next;
    logic [CNT_W-1:0] pend_next;
    logic pend_vld_next;
    always_comb begin
        acc_next = acc_after;
        send_next = send_dec;
        pend_next = pend_reg;
        pend_vld_next = pend_vld_reg;
        if (send_dec == CNT_ZERO && pend_vld_reg) begin
            send_next = pend_reg;
            pend_next = CNT_ZERO;
            pend_vld_next = 1'b0;
        end
        if (rel) begin
            acc_next = CNT_ZERO;
            if (send_next == CNT_ZERO) begin
                send_next = acc_after;
            end else begin
                pend_next = acc_after;
                pend_vld_next = 1'b1;
            end
        end
    end

    wire [TOT_W-1:0] total_next = TOT_W'(acc_next) + TOT_W'(send_next) +
        TOT_W'(pend_next);
    wire ready_next = (total_next < TOT_FULL) && !pend_vld_next;

    // ******************************
    // Delimiter sequencer
    // ******************************
    snp_dstate_e dstate_next;
    logic [1:0] tail_next;
    always_comb begin
        dstate_next = dstate_reg;
        tail_next = tail_reg;
        case (dstate_reg)
            DS_IDLE: begin
                if (byte_in && delim_on && hit1) begin
                    if (two) begin
                        dstate_next = DS_GOT1;
                    end else if (plus) begin
                        dstate_next = DS_TAIL;
                        tail_next = tail_init;
                    end
                end
            end
            DS_GOT1: begin
                if (byte_in && hit2) begin
                    dstate_next = plus ? DS_TAIL : DS_IDLE;
                    tail_next = tail_init;
                end else if (byte_in && !hit1) begin
                    dstate_next = DS_IDLE;
                end
            end
            DS_TAIL: begin
                if (byte_in) begin
                    tail_next = tail_reg - 1'b1;
                    if (tail_reg == TAIL_ONE) begin
                        dstate_next = DS_IDLE;
                    end
                end
            end
            default: begin
                dstate_next = DS_IDLE;
            end
        endcase
        if (!delim_on) begin
            dstate_next = DS_IDLE;
        end
    end

    // ******************************
    // Modem lines and commands
    // ******************************
    // Host 1 wins a same-cycle tie
    wire snp_byte_t cmd_sel = cmd_hit[1] ? HOST_CMD_IN[1].cmd :
        HOST_CMD_IN[0].cmd;
    wire any_cmd = |cmd_hit;
    wire rts_req_next = any_cmd ? cmd_sel[CMD_RTS_BIT] : rts_req_reg;
    wire dtr_req_next = any_cmd ? cmd_sel[CMD_DTR_BIT] : dtr_req_reg;
    wire force_low = CFG_IN.link_low && !LINK_UP_IN;

    // ******************************
    // Registers
    // ******************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (store) begin
            buf_mem[wr_idx_reg] <= RX_DATA_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_idx_reg <= '0;
            rd_idx_reg <= '0;
            acc_reg <= CNT_ZERO;
            send_reg <= CNT_ZERO;
            pend_reg <= CNT_ZERO;
            pend_vld_reg <= 1'b0;
            RX_READY_OUT <= 1'b0;
        end else begin
            wr_idx_reg <= wr_idx_reg + IDX_W'(store) - IDX_W'(rewind);
            rd_idx_reg <= rd_idx_reg + IDX_W'(load);
            acc_reg <= acc_next;
            send_reg <= send_next;
            pend_reg <= pend_next;
            pend_vld_reg <= pend_vld_next;
            RX_READY_OUT <= ready_next;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dstate_reg <= DS_IDLE;
            tail_reg <= '0;
        end else begin
            dstate_reg <= dstate_next;
            tail_reg <= tail_next;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            TX_VALID_OUT <= 1'b0;
            TX_DATA_OUT <= '0;
            TX_LAST_OUT <= 1'b0;
            need_reg <= '0;
        end else begin
            need_reg <= need_next;
            if (load) begin
                TX_VALID_OUT <= 1'b1;
                TX_DATA_OUT <= buf_mem[rd_idx_reg];
                TX_LAST_OUT <= send_reg == CNT_ONE;
            end else if (take) begin
                TX_VALID_OUT <= 1'b0;
            end
        end
    end

    assign TX_DEST_OUT = need_reg;

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rts_req_reg <= 1'b1;
            dtr_req_reg <= 1'b1;
            RTS_OUT <= 1'b1;
            DTR_OUT <= 1'b1;
            CMD_VALID_OUT <= 1'b0;
            CMD_OUT <= '0;
            CFG_ERR_OUT <= 1'b0;
        end else begin
            rts_req_reg <= rts_req_next;
            dtr_req_reg <= dtr_req_next;
            RTS_OUT <= rts_req_next && !force_low;
            DTR_OUT <= dtr_req_next && !force_low;
            CMD_VALID_OUT <= any_cmd;
            CMD_OUT <= any_cmd ? cmd_sel : CMD_OUT;
            CFG_ERR_OUT <= CFG_IN.dest_en == 2'h0;
        end
    end

endmodule

// ===== testbench/snp_properties.sv
`timescale 1ns/1ps
// ****************************
// Port checks
// ****************************
module snp_properties
    import snp_pkg::*;
#(
    parameter int CYC_PER_MS_P = CYC_PER_MS,
    parameter int MS_PER_MIN_P = MS_PER_MIN
) (
    input wire logic CLK_SYS_IN, // Clock
    input wire logic RST_N_IN, // Reset
    input wire snp_pkg::snp_cfg_s CFG_IN, // Settings
    input wire logic TX_VALID_OUT, // Net valid
    input wire snp_pkg::snp_byte_t TX_DATA_OUT, // Net byte
    input wire logic TX_LAST_OUT, // Net last
    input wire logic [1:0] TX_DEST_OUT, // Hosts
    input wire logic [1:0] TX_READY_IN, // Host ready
    input wire logic [1:0] HOST_CONN_IN, // Connected
    input wire snp_pkg::snp_hcmd_s [1:0] HOST_CMD_IN, // Commands
    input wire logic LINK_UP_IN, // Link
    input wire logic PROBE_OUT, // Probe
    input wire logic CLOSE_OUT, // Close
    input wire logic RTS_OUT, // RTS
    input wire logic DTR_OUT, // DTR
    input wire logic CMD_VALID_OUT, // Cmd taken
    input wire snp_pkg::snp_byte_t CMD_OUT, // Cmd
    input wire logic CFG_ERR_OUT // No destination
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);

    // Unaddressed byte is dropped if any host is connected
    wire logic take = TX_VALID_OUT
        && ((TX_READY_IN & TX_DEST_OUT) == TX_DEST_OUT)
        && (TX_DEST_OUT != 2'b00 || HOST_CONN_IN != 2'b00);
    wire logic cmd_any = HOST_CMD_IN[0].valid || HOST_CMD_IN[1].valid;
    wire logic ka_evt = PROBE_OUT || CLOSE_OUT;

    sequence quiet_s;
        (!cmd_any && !CFG_IN.link_low)[*3];
    endsequence
    sequence cmd0_s;
        CFG_IN.drv_ctl_en && HOST_CONN_IN[0] && HOST_CMD_IN[0].valid
            && !HOST_CMD_IN[1].valid;
    endsequence

    tx_hold_a: assert property (TX_VALID_OUT && !take |=> TX_VALID_OUT
        && $stable(TX_DATA_OUT) && $stable(TX_LAST_OUT))
        else $error("network byte changed before taken");
    cmd_ignore_a: assert property (!CFG_IN.drv_ctl_en |=> !CMD_VALID_OUT)
        else $error("command accepted while disabled");
    cmd_accept_a: assert property (cmd0_s |=> CMD_VALID_OUT
        && CMD_OUT == $past(HOST_CMD_IN[0].cmd))
        else $error("command not accepted");
    link_low_a: assert property (CFG_IN.link_low && !LINK_UP_IN
        |=> !RTS_OUT && !DTR_OUT)
        else $error("modem lines high after link loss");
    link_high_a: assert property (quiet_s ##0 $changed(LINK_UP_IN)
        |=> $stable(RTS_OUT) && $stable(DTR_OUT))
        else $error("modem lines follow link");
    alive_off_a: assert property ((CFG_IN.alive_min == 7'h00)[*2]
        |=> !ka_evt)
        else $error("probe or close with keepalive off");
    len_one_a: assert property (CFG_IN.pack_len == 11'h001
        && TX_VALID_OUT |-> TX_LAST_OUT)
        else $error("packet longer than one byte");
    probe_gap_a: assert property (ka_evt |=> (!ka_evt)[*8])
        else $error("keepalive events too close");
    cfg_err_a: assert property (1'b1 |=>
        CFG_ERR_OUT == ($past(CFG_IN.dest_en) == 2'b00))
        else $error("destination error flag wrong");
endmodule

bind snp_packer snp_properties #(.CYC_PER_MS_P(CYC_PER_MS_P),
    .MS_PER_MIN_P(MS_PER_MIN_P)) i_snp_properties (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .CFG_IN(CFG_IN),
    .TX_VALID_OUT(TX_VALID_OUT), .TX_DATA_OUT(TX_DATA_OUT),
    .TX_LAST_OUT(TX_LAST_OUT), .TX_DEST_OUT(TX_DEST_OUT),
    .TX_READY_IN(TX_READY_IN), .HOST_CONN_IN(HOST_CONN_IN),
    .HOST_CMD_IN(HOST_CMD_IN), .LINK_UP_IN(LINK_UP_IN),
    .PROBE_OUT(PROBE_OUT), .CLOSE_OUT(CLOSE_OUT), .RTS_OUT(RTS_OUT),
    .DTR_OUT(DTR_OUT), .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT),
    .CFG_ERR_OUT(CFG_ERR_OUT));

// ===== testbench/snp_host_model.sv
`timescale 1ns/1ps
// ****************************
// Remote hosts
// ****************************
module snp_host_model (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic slow_in, // Random stalls
    input wire logic ack_en_in, // Answer probes
    input wire logic probe_in, // Probe seen
    output logic [1:0] ready_out, // Takes byte
    output logic ack_out // Probe answer
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_out <= 2'b00;
            ack_out <= 1'b0;
        end else begin
            ready_out <= slow_in ? 2'($urandom) : 2'b11;
            ack_out <= probe_in && ack_en_in;
        end
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
    import snp_pkg::*;
    localparam int CPM = 4, MPM = 4;
    logic clk, rst_n, rx_valid, slow, ack_en, link_up, ack, rx_ready;
    logic tx_valid, tx_last, probe, close, rts, dtr, cmd_valid, cfg_err;
    snp_byte_t rx_data, tx_data, cmd;
    logic [1:0] tx_dest, tx_ready, conn, jam;
    snp_cfg_s cfg;
    snp_hcmd_s [1:0] hcmd;
    int num_errors, num_checks, st, tl, probes, closes;
    logic [8:0] exp_q[$];
    logic [7:0] acc[$];

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    snp_packer #(.CYC_PER_MS_P(CPM), .MS_PER_MIN_P(MPM)) i_snp_packer (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CFG_IN(cfg),
        .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data),
        .RX_READY_OUT(rx_ready), .TX_VALID_OUT(tx_valid),
        .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last), .TX_DEST_OUT(tx_dest),
        .TX_READY_IN(tx_ready), .HOST_CONN_IN(conn), .HOST_JAM_IN(jam),
        .HOST_CMD_IN(hcmd), .LINK_UP_IN(link_up), .PROBE_ACK_IN(ack),
        .PROBE_OUT(probe), .CLOSE_OUT(close), .RTS_OUT(rts), .DTR_OUT(dtr),
        .CMD_VALID_OUT(cmd_valid), .CMD_OUT(cmd), .CFG_ERR_OUT(cfg_err));

    snp_host_model i_snp_host_model (.clk_in(clk), .rst_n_in(rst_n),
        .slow_in(slow), .ack_en_in(ack_en), .probe_in(probe),
        .ready_out(tx_ready), .ack_out(ack));

    // ****************************
    // Checking and model
    // ****************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic flush();
        foreach (acc[i]) exp_q.push_back({i == acc.size() - 1, acc[i]});
        acc.delete();
        st = 0;
    endtask

    task automatic model(input logic [7:0] b);
        logic isd, dlm;
        int need;
        isd = 1'b0;
        dlm = cfg.pack_len == 11'h000 && cfg.d1_en;
        need = cfg.dact == DA_PLUS1 ? 1 : cfg.dact == DA_PLUS2 ? 2 : 0;
        if (dlm && st == 2) begin
            tl++;
        end else if (dlm && st == 0 && b == cfg.d1) begin
            isd = 1'b1;
            st = cfg.d2_en ? 1 : 2;
            tl = 0;
        end else if (dlm && st == 1 && b == cfg.d2) begin
            isd = 1'b1;
            st = 2;
            tl = 0;
        end
        if (!(isd && cfg.dact == DA_STRIP)) acc.push_back(b);
        if (acc.size() == cfg.pack_len || acc.size() == BUF_BYTES
                || (st == 2 && tl == need)) flush();
    endtask

    task automatic send(input logic [7:0] b);
        int n = 0;
        rx_valid = 1'b1;
        rx_data = b;
        do begin
            @(posedge clk);
            n++;
        end while (rx_ready !== 1'b1 && n < 2000);
        check(16'(n < 2000), 16'h0001);
        model(b);
        #1;
    endtask

    task automatic drain(input int lim, input bit gap);
        int n = 0;
        rx_valid = 1'b0;
        if (gap) flush();
        while ((exp_q.size() > 0 || tx_valid !== 1'b0) && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(16'(exp_q.size()), 16'h0000);
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic cmd_pulse(input int h, input logic [7:0] c);
        hcmd[h] = {1'b1, c};
        @(posedge clk);
        #1;
        hcmd[h] = '0;
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        probes += (probe === 1'b1);
        closes += (close === 1'b1);
        if (tx_valid === 1'b1 && (tx_ready & tx_dest) === tx_dest
                && tx_dest !== 2'b00)
            check({tx_last, tx_data}, exp_q.size() ? exp_q.pop_front() : 16'hffff);
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    // ****************************
    // Tests
    // ****************************
    initial begin
        void'($urandom(32'h0ddb));
        rst_n = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        slow = 1'b1;
        ack_en = 1'b1;
        link_up = 1'b1;
        conn = 2'b11;
        jam = 2'b00;
        hcmd = '0;
        cfg = '0;
        cfg.max_two = 1'b1;
        cfg.dest_en = 2'b11;
        repeat (12) @(posedge clk);
        #1;
        check({rx_ready, tx_valid, rts, dtr}, 16'h0003);
        rst_n = 1'b1;
        // Gap above one character time
        cfg.gap_ms = 16'h0014;
        for (int k = 1; k <= 3; k += 2) begin
            cfg.pack_len = 11'(k);
            repeat (7) send(8'($urandom));
            drain(400, 1);
        end
        $display("length test done");
        cfg.pack_len = 11'h000;
        cfg.gap_ms = 16'h0000;
        cfg.d1_en = 1'b1;
        cfg.d1 = 8'hff;
        repeat (1000) send({1'b0, 7'($urandom)});
        rx_valid = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        check(tx_valid, 16'h0000);
        repeat (24) send({1'b0, 7'($urandom)});
        drain(6000, 0);
        $display("full buffer test done");
        slow = 1'b0;
        cfg.gap_ms = 16'h0002;
        cfg.d1 = 8'h8d;
        cfg.d2 = 8'h8a;
        for (int m = 0; m < 8; m++) begin
            cfg.dact = snp_dact_e'(m % 4);
            cfg.d2_en = 1'(m / 4);
            repeat (3) send({1'b0, 7'($urandom)});
            send(cfg.d1);
            if (cfg.d2_en) send(cfg.d2);
            repeat (3) send({1'b0, 7'($urandom)});
            drain(200, 1);
        end
        $display("delimiter test done");
        cfg.skip_jam = 1'b1;
        jam = 2'b10;
        settle();
        check(tx_dest, 16'h0001);
        cfg.skip_jam = 1'b0;
        settle();
        check(tx_dest, 16'h0003);
        cfg.max_two = 1'b0;
        settle();
        check(tx_dest, 16'h0001);
        cfg.max_two = 1'b1;
        jam = 2'b00;
        $display("host test done");
        cfg.drv_ctl_en = 1'b1;
        cmd_pulse(0, 8'h5c);
        settle();
        check({cmd, dtr, rts}, {8'h5c, 2'b00});
        cfg.drv_ctl_en = 1'b0;
        cmd_pulse(0, 8'h03);
        settle();
        check({cmd, dtr, rts}, {8'h5c, 2'b00});
        cfg.drv_ctl_en = 1'b1;
        cmd_pulse(0, 8'h01);
        cmd_pulse(1, 8'h02);
        settle();
        check({cmd, dtr, rts}, {8'h02, 2'b10});
        cmd_pulse(1, 8'h03);
        settle();
        link_up = 1'b0;
        settle();
        check({dtr, rts}, 16'h0003);
        cfg.link_low = 1'b1;
        settle();
        check({dtr, rts}, 16'h0000);
        link_up = 1'b1;
        settle();
        check({dtr, rts}, 16'h0003);
        cfg.link_low = 1'b0;
        $display("modem test done");
        for (int a = 0; a < 3; a++) begin
            ack_en = a != 1;
            cfg.alive_min = (a == 2) ? 7'h00 : 7'h01;
            settle();
            probes = 0;
            closes = 0;
            repeat (6 * MPM * CPM + 4) @(posedge clk);
            #1;
            check(16'((probes + closes) / 6), 16'(a != 2));
            check(16'(closes > 0), 16'(a == 1));
        end
        $display("keepalive test done");
        end_of_test();
    end
endmodule
